// ==== hw/wtw_pkg.sv ====
// Shared constants and types for the kick watchdog and its host kicker
package wtw_pkg;
  localparam int          CNT_W            = 32;
  localparam int          CLK_MHZ          = 125;
  // Default periods in microseconds; converted to pclk cycles below
  localparam int          UPPER_US         = 17000;
  localparam int          RESET_US         = 5000;
  localparam int          SETTLE_US        = 200;
  localparam int          LOWER_DIV        = 31;
  localparam logic [31:0] UPPER_CYC_RST    = 32'(UPPER_US * CLK_MHZ);
  localparam logic [31:0] RESET_CYC_RST    = 32'(RESET_US * CLK_MHZ);
  localparam logic [31:0] SETTLE_CYC_RST   = 32'(SETTLE_US * CLK_MHZ);
  // APB register map of the device wrapper
  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_UPPER       = 8'h04;
  localparam logic [7:0]  ADDR_RESET       = 8'h08;
  localparam logic [7:0]  ADDR_SETTLE      = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS      = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h18;
  localparam int          CTRL_MODE_BIT    = 0;
  localparam int          CTRL_DIS_N_BIT   = 1;
  localparam logic [1:0]  CTRL_RST         = 2'h2;
  localparam int          IRQ_FAULT_BIT    = 0;
  localparam int          IRQ_ARMED_BIT    = 1;
  // Host kicker registers
  localparam logic [7:0]  ADDR_KICK_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_KICK_PERIOD = 8'h04;
  localparam logic [7:0]  ADDR_KICK_STAT   = 8'h08;
  localparam logic [31:0] KICK_PERIOD_RST  = 32'(UPPER_CYC_RST / 2);

  typedef enum logic [1:0] {WTW_HOLD, WTW_SETTLE, WTW_FIRST, WTW_RUN} wtw_state_t;
endpackage

// ==== hw/wtw_link_if.sv ====
// Pin-level link between the kick watchdog and the host
`timescale 1ns/1ps
interface wtw_link_if;
  logic kick_in;
  logic supervisor_fault_n;
  logic sys_reset_n;
  modport device (input kick_in, input sys_reset_n, output supervisor_fault_n);
  modport host   (output kick_in, output sys_reset_n, input supervisor_fault_n);
endinterface

// ==== hw/wtw_watchdog.sv ====
// Window/timeout kick watchdog with APB control and status
//
// Overview of operation
// R1: Mode input low window, high timeout.
// R2: Window mode counts falling kick edges only.
// R3: Ignore kicks until reset timer and settle.
// R4: Window: first falling edge before upper bound.
// R5: Window: later edges between lower and upper.
// R6: Fault drives fault low, runs reset timer.
// R7: System reset stays released during fault.
// R8: After restart, ignore, then first-edge check.
// R9: Timeout mode accepts both edge polarities.
// R10: Timeout: first edge before upper bound.
// R11: Timeout: each edge within upper, no minimum.
// R12: Lower bound is upper bound over 31.
// R13: Fault released while system reset low.
// R14: Disable input high stops all supervision.
// R15: No kicks gives fault pulse train.
// R16: Periods are programmable clock cycle counts.
// R17: Kick passes two-stage synchronizer first.
`timescale 1ns/1ps
module wtw_watchdog
  import wtw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  wtw_link_if.device       link
);
  import wtw_pkg::*;

  // Register state
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [31:0] upper_r, upper_nxt, reset_r, reset_nxt, settle_r, settle_nxt;
  logic [1:0]  istat_r, istat_nxt, imask_r, imask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
  // Supervisor state
  wtw_state_t  st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic        fault_n_r, fault_n_nxt;
  logic [2:0]  kick_sync_r;
  logic [1:0]  rst_sync_r;
  logic        mode_win, enabled, edge_fall, edge_any, kick, sys_rst_low, armed;
  logic        ev_fault, ev_armed, acc, wr, rd;
  logic [31:0] lower_cyc;

  assign mode_win    = ~ctrl_r[CTRL_MODE_BIT];                        // R1
  assign enabled     = ~ctrl_r[CTRL_DIS_N_BIT];                       // R14
  assign lower_cyc   = upper_r / 32'(LOWER_DIV);                      // R12
  assign sys_rst_low = ~rst_sync_r[1];
  assign edge_fall   = kick_sync_r[2] & ~kick_sync_r[1];              // R2
  assign edge_any    = kick_sync_r[2] ^ kick_sync_r[1];               // R9
  assign kick        = mode_win ? edge_fall : edge_any;
  assign armed       = (st_r == WTW_FIRST) || (st_r == WTW_RUN);
  assign acc         = psel & penable & ~pready_r;
  assign wr          = acc & pwrite;
  assign rd          = acc & ~pwrite;

  // Synchronizers; stage 0 is read only by stage 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_sync_r <= 3'h7;
      rst_sync_r  <= 2'h3;
    end else begin
      kick_sync_r <= {kick_sync_r[1:0], link.kick_in};                // R17
      rst_sync_r  <= {rst_sync_r[0], link.sys_reset_n};
    end
  end

  // Supervisor sequence
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r + 32'h1;
    fault_n_nxt = fault_n_r;
    ev_fault    = 1'b0;
    ev_armed    = 1'b0;
    if (!enabled || sys_rst_low) begin
      // Supervision off, or system reset restarts it; fault never low with it
      st_nxt      = WTW_HOLD;                                         // R14
      cnt_nxt     = 32'h0;
      fault_n_nxt = 1'b1;                                             // R13
    end else begin
      unique case (st_r)
        WTW_HOLD: begin
          // Reset timer: kicks ignored here
          if (cnt_r >= reset_r) begin                                 // R3 R15
            st_nxt      = WTW_SETTLE;
            cnt_nxt     = 32'h0;
            fault_n_nxt = 1'b1;
          end
        end
        WTW_SETTLE: begin
          if (cnt_r >= settle_r) begin                                // R3 R8
            st_nxt   = WTW_FIRST;
            cnt_nxt  = 32'h0;
            ev_armed = 1'b1;
          end
        end
        WTW_FIRST: begin
          if (kick) begin                                             // R4 R10
            st_nxt  = WTW_RUN;
            cnt_nxt = 32'h0;
          end else if (cnt_r >= upper_r) begin
            ev_fault = 1'b1;
          end
        end
        WTW_RUN: begin
          if (kick && mode_win && cnt_r <= lower_cyc) begin           // R5
            ev_fault = 1'b1;
          end else if (kick) begin                                    // R11
            cnt_nxt = 32'h0;
          end else if (cnt_r >= upper_r) begin
            ev_fault = 1'b1;
          end
        end
      endcase
      if (ev_fault) begin
        // Fault low and restart through the reset timer; system reset untouched
        st_nxt      = WTW_HOLD;                                       // R6 R7 R8
        cnt_nxt     = 32'h0;
        fault_n_nxt = 1'b0;                                           // R15
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= WTW_HOLD;
      cnt_r     <= 32'h0;
      fault_n_r <= 1'b1;
    end else begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  assign link.supervisor_fault_n = fault_n_r;

  // APB slave: one wait state per access phase, answer one cycle after access starts
  always_comb begin
    ctrl_nxt    = ctrl_r;
    upper_nxt   = upper_r;
    reset_nxt   = reset_r;
    settle_nxt  = settle_r;
    imask_nxt   = imask_r;
    istat_nxt   = istat_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = acc;
    pslverr_nxt = 1'b0;
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL:     ctrl_nxt   = pwdata[1:0];
        ADDR_UPPER:    upper_nxt  = pwdata;                           // R16
        ADDR_RESET:    reset_nxt  = pwdata;                           // R16
        ADDR_SETTLE:   settle_nxt = pwdata;                           // R16
        ADDR_IRQ_STAT: istat_nxt  = istat_r & ~pwdata[1:0];
        ADDR_IRQ_MASK: imask_nxt  = pwdata[1:0];
        ADDR_STATUS:   pslverr_nxt = 1'b0;
        default:       pslverr_nxt = 1'b1;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        ADDR_CTRL:     prdata_nxt = {30'h0, ctrl_r};
        ADDR_UPPER:    prdata_nxt = upper_r;
        ADDR_RESET:    prdata_nxt = reset_r;
        ADDR_SETTLE:   prdata_nxt = settle_r;
        ADDR_STATUS:   prdata_nxt = {27'h0, sys_rst_low, armed, st_r, fault_n_r};
        ADDR_IRQ_STAT: prdata_nxt = {30'h0, istat_r};
        ADDR_IRQ_MASK: prdata_nxt = {30'h0, imask_r};
        default: begin
          prdata_nxt  = 32'h0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    // Set wins over a same-cycle clear
    istat_nxt[IRQ_FAULT_BIT] = istat_nxt[IRQ_FAULT_BIT] | ev_fault;
    istat_nxt[IRQ_ARMED_BIT] = istat_nxt[IRQ_ARMED_BIT] | ev_armed;
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= CTRL_RST;
      upper_r   <= UPPER_CYC_RST;
      reset_r   <= RESET_CYC_RST;
      settle_r  <= SETTLE_CYC_RST;
      istat_r   <= 2'h0;
      imask_r   <= 2'h0;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      upper_r   <= upper_nxt;
      reset_r   <= reset_nxt;
      settle_r  <= settle_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;
endmodule

// ==== hw/wtw_host.sv ====
// Host end: periodic kick generator and system reset driver under APB control
`timescale 1ns/1ps
module wtw_host
  import wtw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  wtw_link_if.host         link
);
  import wtw_pkg::*;

  // Control: bit0 kick run, bit1 assert system reset, bit2 toggle (timeout) vs pulse low
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [31:0] period_r, period_nxt, cnt_r, cnt_nxt;
  logic        kick_r, kick_nxt, srst_n_r, srst_n_nxt;
  logic [1:0]  fault_sync_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt, acc;

  assign acc = psel & penable & ~pready_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_sync_r <= 2'h3;
    else          fault_sync_r <= {fault_sync_r[0], link.supervisor_fault_n};
  end

  always_comb begin
    ctrl_nxt    = ctrl_r;
    period_nxt  = period_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = acc;
    pslverr_nxt = 1'b0;
    cnt_nxt     = cnt_r + 32'h1;
    kick_nxt    = kick_r;
    if (acc && pwrite) begin
      unique case (paddr)
        ADDR_KICK_CTRL:   ctrl_nxt   = pwdata[2:0];
        ADDR_KICK_PERIOD: period_nxt = pwdata;
        default:          pslverr_nxt = 1'b1;
      endcase
    end
    if (acc && !pwrite) begin
      unique case (paddr)
        ADDR_KICK_CTRL:   prdata_nxt = {29'h0, ctrl_r};
        ADDR_KICK_PERIOD: prdata_nxt = period_r;
        ADDR_KICK_STAT:   prdata_nxt = {30'h0, kick_r, fault_sync_r[1]};
        default: begin
          prdata_nxt  = 32'h0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (!ctrl_r[0]) begin
      cnt_nxt  = 32'h0;
      kick_nxt = 1'b1;
    end else if (cnt_r >= period_r) begin
      // Pulse mode gives one falling edge per period; toggle gives an edge each period
      cnt_nxt  = 32'h0;
      kick_nxt = ctrl_r[2] ? ~kick_r : 1'b0;
    end else if (!ctrl_r[2]) begin
      kick_nxt = 1'b1;
    end
    srst_n_nxt = ~ctrl_r[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= 3'h0;
      period_r  <= KICK_PERIOD_RST;
      cnt_r     <= 32'h0;
      kick_r    <= 1'b1;
      srst_n_r  <= 1'b1;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      period_r  <= period_nxt;
      cnt_r     <= cnt_nxt;
      kick_r    <= kick_nxt;
      srst_n_r  <= srst_n_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign link.kick_in     = kick_r;
  assign link.sys_reset_n = srst_n_r;
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
endmodule

// ==== testbench/wtw_link_properties.sv ====
// Link-level checks on the wires between watchdog and host
`timescale 1ns/1ps
module wtw_link_properties #(
  parameter int UPPER_CYC  = 310,
  parameter int RESET_CYC  = 40,
  parameter int SETTLE_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic kick_in,
  input wire logic supervisor_fault_n,
  input wire logic sys_reset_n
);
  int   low_r;
  int   low_nxt;
  int   calm_r;
  int   calm_nxt;
  int   gap_r;
  int   gap_nxt;
  logic kick_r;
  logic rseen_r;
  logic rseen_nxt;

  // The calm and gap counters saturate so long idle stretches never wrap; low_r does not
  always_comb begin
    low_nxt   = supervisor_fault_n ? 0 : low_r + 1;
    calm_nxt  = (supervisor_fault_n && sys_reset_n) ? calm_r + int'(calm_r < 99999) : 0;
    gap_nxt   = (kick_r && !kick_in) ? 0 : gap_r + int'(gap_r < 99999);
    rseen_nxt = !sys_reset_n || (rseen_r && !supervisor_fault_n);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r   <= 0;
      calm_r  <= 0;
      gap_r   <= 0;
      kick_r  <= 1'b1;
      rseen_r <= 1'b0;
    end else begin
      low_r   <= low_nxt;
      calm_r  <= calm_nxt;
      gap_r   <= gap_nxt;
      kick_r  <= kick_in;
      rseen_r <= rseen_nxt;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RST_WINS: assert property ((!sys_reset_n) [*5] |-> supervisor_fault_n) else $error("both low");
  AST_REL_HOLD: assert property ((!sys_reset_n) [*5] ##1 sys_reset_n |-> supervisor_fault_n [*8]) else $error("rel");
  AST_LOW_MIN: assert property ($rose(supervisor_fault_n) && !rseen_r |-> low_r >= RESET_CYC - 1) else $error("short");
  AST_LOW_MAX: assert property (!supervisor_fault_n |-> low_r <= RESET_CYC + 1) else $error("fault low too long");
  AST_QUIET: assert property ($fell(supervisor_fault_n) |-> calm_r > SETTLE_CYC) else $error("kick not ignored");
  AST_CAUSE: assert property ($fell(supervisor_fault_n) |-> gap_r >= UPPER_CYC || gap_r <= 10) else $error("cause");
  AST_HIGH_MIN: assert property ($rose(supervisor_fault_n) |-> supervisor_fault_n [*8]) else $error("refault");
  AST_LOW_HOLD: assert property ($fell(supervisor_fault_n) && sys_reset_n |=> !supervisor_fault_n [*3]) else $error("glitch");
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the watchdog and host kicker pair
`timescale 1ns/1ps
module tb_top;
  import wtw_pkg::*;
  localparam int UP = 310;
  localparam int RS = 40;
  localparam int ST = 20;
  logic        pclk;
  logic        presetn;
  logic        penable;
  logic        pwrite;
  logic [1:0]  psel;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata [2];
  logic        pready [2];
  logic        pslverr [2];
  logic        irq;
  int          err_total;
  int          compares;
  int          cyc;
  int          n_fall;
  wtw_link_if link ();
  wtw_watchdog wtw_watchdog_i (.pclk(pclk), .presetn(presetn), .psel(psel[0]), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]), .irq(irq), .link(link));
  wtw_host wtw_host_i (.pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]), .link(link));
  wtw_link_properties #(.UPPER_CYC(UP), .RESET_CYC(RS), .SETTLE_CYC(ST)) wtw_link_properties_i (.pclk(pclk),
    .presetn(presetn), .kick_in(link.kick_in), .supervisor_fault_n(link.supervisor_fault_n),
    .sys_reset_n(link.sys_reset_n));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(negedge link.supervisor_fault_n) n_fall++;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out;
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high; no cycle count assumed
  task automatic apb(int s, logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] rd, output logic er);
    psel[s] <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready[s] !== 1'b1);
    rd = prdata[s];
    er = pslverr[s];
    psel[s] <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(int s, logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(s, 1'b1, a, d, r, e);
  endtask
  task automatic rdc(int s, logic [7:0] a, logic [31:0] m, logic [31:0] x, logic xe);
    logic [31:0] r;
    logic        e;
    apb(s, 1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk(32'(e), 32'(xe));
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wf(logic lvl, int lim);
    int n;
    n = 0;
    while (link.supervisor_fault_n !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(link.supervisor_fault_n), 32'(lvl));
  endtask
  task automatic len(logic lvl, output int n);
    n = 0;
    while (link.supervisor_fault_n === lvl) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic s_regs;
    rdc(0, ADDR_CTRL, 32'h3, 32'(CTRL_RST), 1'b0);
    rdc(0, ADDR_STATUS, 32'h13, 32'h1, 1'b0);
    rdc(1, ADDR_KICK_STAT, 32'h3, 32'h3, 1'b0);
    rdc(0, 8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1);
    rdc(1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
    wr(0, ADDR_UPPER, 32'(UP));
    wr(0, ADDR_RESET, 32'(RS));
    wr(0, ADDR_SETTLE, 32'(ST));
    rdc(0, ADDR_UPPER, 32'hFFFFFFFF, 32'(UP), 1'b0);
    wr(0, ADDR_IRQ_MASK, 32'h1);
  endtask
  task automatic s_window;
    int nf;
    wr(1, ADDR_KICK_PERIOD, 32'h3C);
    wr(1, ADDR_KICK_CTRL, 32'h1);
    wr(0, ADDR_CTRL, 32'h0);
    nf = n_fall;
    idle(1500);
    wr(1, ADDR_KICK_PERIOD, 32'hC);
    idle(600);
    chk(32'(n_fall), 32'(nf));
    wr(1, ADDR_KICK_PERIOD, 32'h8);
    wf(1'b0, 80);
    idle(3);
    chk(32'(irq), 32'h1);
    wr(1, ADDR_KICK_PERIOD, 32'h3C);
    wf(1'b1, RS + 10);
    wr(0, ADDR_IRQ_STAT, 32'h1);
    rdc(0, ADDR_IRQ_STAT, 32'h1, 32'h0, 1'b0);
  endtask
  task automatic s_train;
    int n;
    wr(0, ADDR_IRQ_MASK, 32'h0);
    wr(1, ADDR_KICK_CTRL, 32'h0);
    wf(1'b0, UP + 80);
    chk(32'(link.sys_reset_n), 32'h1);
    len(1'b0, n);
    chk(32'(n >= RS - 1 && n <= RS + 1), 32'h1);
    len(1'b1, n);
    chk(32'(n >= ST + UP - 1 && n <= ST + UP + 4), 32'h1);
    chk(32'(irq), 32'h0);
    rdc(0, ADDR_IRQ_STAT, 32'h3, 32'h3, 1'b0);
  endtask
  task automatic s_timeout;
    int nf;
    wf(1'b1, RS + 10);
    wr(0, ADDR_CTRL, 32'h2);
    wr(1, ADDR_KICK_PERIOD, 32'hC8);
    wr(1, ADDR_KICK_CTRL, 32'h5);
    wr(0, ADDR_CTRL, 32'h1);
    nf = n_fall;
    idle(1800);
    wr(1, ADDR_KICK_PERIOD, 32'h3);
    idle(400);
    chk(32'(n_fall), 32'(nf));
  endtask
  task automatic s_sysrst;
    wr(1, ADDR_KICK_CTRL, 32'h0);
    wf(1'b0, UP + 80);
    wr(1, ADDR_KICK_CTRL, 32'h2);
    idle(6);
    chk(32'(link.supervisor_fault_n), 32'h1);
    rdc(0, ADDR_STATUS, 32'h13, 32'h11, 1'b0);
    wr(1, ADDR_KICK_CTRL, 32'h0);
  endtask
  task automatic s_disable;
    int nf;
    wf(1'b1, RS + 40);
    wr(0, ADDR_CTRL, 32'h2);
    nf = n_fall;
    idle(3 * UP);
    chk(32'(n_fall), 32'(nf));
  endtask
  initial begin
    presetn   = 1'b0;
    psel      = 2'h0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    err_total = 0;
    compares  = 0;
    cyc       = 0;
    n_fall    = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_window();
    s_train();
    s_timeout();
    s_sysrst();
    s_disable();
    close_out();
  end
endmodule
